// ===== rtl/lpwk_defines.svh
`ifndef LPWK_DEFINES_SVH
`define LPWK_DEFINES_SVH

// ----------------------------------------
// Clock and wake-up time budgets
// ----------------------------------------
`define LPWK_CLK_PERIOD_NS       4
`define LPWK_BACKUP_WAKE_MAX_NS  100000
`define LPWK_WAIT_WAKE_MAX_NS    10000
`define LPWK_BACKUP_WAKE_CYC     (`LPWK_BACKUP_WAKE_MAX_NS / `LPWK_CLK_PERIOD_NS)
`define LPWK_WAIT_WAKE_CYC       (`LPWK_WAIT_WAKE_MAX_NS / `LPWK_CLK_PERIOD_NS)

// ----------------------------------------
// Settling counts inside the budgets
// ----------------------------------------
`define LPWK_REG_SETTLE_CYC      24000
`define LPWK_RC_SETTLE_CYC       64

// ----------------------------------------
// Wake source vector layout
// ----------------------------------------
`define LPWK_NUM_PINS            16
`define LPWK_SRC_SM              16
`define LPWK_SRC_CAL             17
`define LPWK_SRC_RTT             18
`define LPWK_SRC_USB             19
`define LPWK_NUM_SRC             20

`endif

// ===== rtl/lpwk_pkg.sv
package lpwk_pkg;

    typedef enum logic [2:0] {
        LPWK_ACTIVE,
        LPWK_SLEEP,
        LPWK_WAIT,
        LPWK_BACKUP,
        LPWK_BK_REG,
        LPWK_BK_PWR,
        LPWK_FS_RC
    } lpwk_state_t;

endpackage

// ===== rtl/lpwk_wake_sync.sv
`timescale 1ns/10ps

module lpwk_wake_sync #(
    parameter int WIDTH = 20
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] src_n,
    input  wire logic [WIDTH-1:0] src_en,
    output logic      [WIDTH-1:0] src_active
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // ----------------------------------------
    // Two-stage synchroniser, idle level high
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_reg <= {WIDTH{1'b1}};
            sync_reg <= {WIDTH{1'b1}};
        end else begin
            meta_reg <= src_n;
            sync_reg <= meta_reg;
        end
    end

    // Low level wakes; a disabled source is masked out
    assign src_active = ~sync_reg & src_en;

endmodule

// ===== rtl/lpwk_ctrl.sv
`timescale 1ns/10ps
`include "lpwk_defines.svh"

module lpwk_ctrl
    import lpwk_pkg::*;
#(
    parameter logic [15:0] REG_SETTLE_CYC = 16'(`LPWK_REG_SETTLE_CYC),
    parameter logic [15:0] RC_SETTLE_CYC  = 16'(`LPWK_RC_SETTLE_CYC),
    parameter logic [15:0] BACKUP_BUDGET  = 16'(`LPWK_BACKUP_WAKE_CYC),
    parameter logic [15:0] WAIT_BUDGET    = 16'(`LPWK_WAIT_WAKE_CYC)
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      wfe_exec,
    input  wire logic                      wfi_exec,
    input  wire logic                      deep_sleep_bit,
    input  wire logic                      low_power_select,
    input  wire logic                      irq_pending,
    input  wire logic [`LPWK_NUM_PINS-1:0] wake_pins_n,
    input  wire logic                      supply_monitor_alarm_n,
    input  wire logic                      calendar_alarm_n,
    input  wire logic                      real_time_timer_alarm_n,
    input  wire logic                      usb_wakeup_n,
    input  wire logic [`LPWK_NUM_PINS-1:0] wake_pins_en,
    input  wire logic                      supply_monitor_en,
    input  wire logic                      calendar_en,
    input  wire logic                      real_time_timer_en,
    input  wire logic                      usb_wakeup_en,
    input  wire logic                      periph_domain_en,
    input  wire logic                      sleep_periph_clk_keep,
    input  wire logic                      master_clk_release,
    output logic                           regulator_on,
    output logic                           core_pwr_on,
    output logic                           sram_pwr_on,
    output logic                           periph_pwr_on,
    output logic                           cpu_clk_on,
    output logic                           mem_clk_on,
    output logic                           periph_clk_on,
    output logic                           cpu_reset,
    output logic                           io_hold,
    output logic                           io_default_cfg,
    output logic                           fast_rc_restart,
    output logic                           master_clk_on_rc,
    output logic                           fast_startup_req,
    output logic                           low_power_active
);

    // ----------------------------------------
    // Wake source conditioning
    // ----------------------------------------
    logic [`LPWK_NUM_SRC-1:0] src_n;
    logic [`LPWK_NUM_SRC-1:0] src_en;
    logic [`LPWK_NUM_SRC-1:0] src_active;

    assign src_n  = {usb_wakeup_n, real_time_timer_alarm_n, calendar_alarm_n,
                     supply_monitor_alarm_n, wake_pins_n};
    assign src_en = {usb_wakeup_en, real_time_timer_en, calendar_en,
                     supply_monitor_en, wake_pins_en};

    lpwk_wake_sync #(
        .WIDTH      (`LPWK_NUM_SRC)
    ) u_sync (
        .core_clk   (core_clk),
        .rst        (rst),
        .src_n      (src_n),
        .src_en     (src_en),
        .src_active (src_active)
    );

    wire fast_evt   = |src_active[`LPWK_SRC_RTT:0];
    wire backup_evt = |src_active[`LPWK_SRC_RTT:0];
    wire usb_evt    = src_active[`LPWK_SRC_USB];

    // ----------------------------------------
    // State and counters
    // ----------------------------------------
    lpwk_state_t state_reg;
    lpwk_state_t state_next;
    logic        entry_wfe_reg;
    logic        entry_wfe_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [15:0] lat_reg;
    logic [15:0] lat_next;

    wire reg_done = (cnt_reg == REG_SETTLE_CYC - 16'h0001);
    wire rc_done  = (cnt_reg == RC_SETTLE_CYC - 16'h0001);

    wire enter_backup = wfe_exec & deep_sleep_bit;
    wire enter_wait   = wfe_exec & ~deep_sleep_bit & low_power_select;
    wire enter_sleep  = (wfe_exec | wfi_exec) & ~deep_sleep_bit
                        & ~low_power_select;

    // Sleep by interrupt-wait ignores events; by event-wait takes both
    wire sleep_wake = irq_pending | (entry_wfe_reg & (fast_evt | usb_evt));
    wire wait_wake  = fast_evt | usb_evt;

    always_comb begin
        state_next     = state_reg;
        entry_wfe_next = entry_wfe_reg;
        case (state_reg)
            LPWK_ACTIVE: begin
                if (enter_backup) begin
                    state_next = LPWK_BACKUP;
                end else if (enter_wait) begin
                    state_next = LPWK_WAIT;
                end else if (enter_sleep) begin
                    state_next     = LPWK_SLEEP;
                    entry_wfe_next = wfe_exec;
                end
            end
            LPWK_SLEEP: begin
                if (sleep_wake) begin
                    state_next = LPWK_ACTIVE;
                end
            end
            LPWK_WAIT: begin
                if (wait_wake) begin
                    state_next = LPWK_FS_RC;
                end
            end
            LPWK_BACKUP: begin
                if (backup_evt) begin
                    state_next = LPWK_BK_REG;
                end
            end
            LPWK_BK_REG: begin
                if (reg_done) begin
                    state_next = LPWK_BK_PWR;
                end
            end
            LPWK_BK_PWR: begin
                if (rc_done) begin
                    state_next = LPWK_ACTIVE;
                end
            end
            LPWK_FS_RC: begin
                if (rc_done) begin
                    state_next = LPWK_ACTIVE;
                end
            end
            default: begin
                state_next = LPWK_ACTIVE;
            end
        endcase
    end

    assign cnt_next = (state_next != state_reg) ? 16'h0000 : cnt_reg + 16'h0001;

    // Latency since the wake event, held for budget checks
    wire in_wake = (state_reg == LPWK_BK_REG) || (state_reg == LPWK_BK_PWR)
                   || (state_reg == LPWK_FS_RC);
    assign lat_next = in_wake ? lat_reg + 16'h0001 : 16'h0000;

    // ----------------------------------------
    // Output decode from the next state; fast startup request from the current state
    // ----------------------------------------
    wire n_active = (state_next == LPWK_ACTIVE);
    wire n_sleep  = (state_next == LPWK_SLEEP);
    wire n_backup = (state_next == LPWK_BACKUP);
    wire n_bkreg  = (state_next == LPWK_BK_REG);
    wire n_bkpwr  = (state_next == LPWK_BK_PWR);
    wire n_fsrc   = (state_next == LPWK_FS_RC);
    wire n_bkseq  = n_bkreg | n_bkpwr;

    // Core supply is only cut in backup and its first ramp step
    wire regulator_next  = ~n_backup;
    wire core_pwr_next   = ~(n_backup | n_bkreg);
    wire sram_pwr_next   = ~(n_backup | n_bkreg);
    wire periph_pwr_next = periph_domain_en & ~(n_backup | n_bkseq);
    wire cpu_clk_next    = n_active;
    wire mem_clk_next    = n_active;
    wire periph_clk_next = periph_domain_en
                           & (n_active | (n_sleep & sleep_periph_clk_keep));
    wire cpu_reset_next  = n_backup | n_bkseq;
    wire io_hold_next    = ~n_active;
    wire io_default_next = n_bkseq;
    wire rc_restart_next = n_fsrc | n_bkpwr;
    wire fs_req_next     = ((state_reg == LPWK_WAIT)
                           | ((state_reg == LPWK_SLEEP) & entry_wfe_reg)) & fast_evt;

    // Master clock stays on the RC until software releases it; a wait or backup wake wins
    wire wake_done   = (state_reg != LPWK_ACTIVE) & n_active & (state_reg != LPWK_SLEEP);
    wire mclk_rc_next = wake_done | n_fsrc | n_bkpwr
                        | (master_clk_on_rc & ~master_clk_release);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg     <= LPWK_ACTIVE;
            entry_wfe_reg <= 1'b0;
            cnt_reg       <= 16'h0000;
            lat_reg       <= 16'h0000;
        end else begin
            state_reg     <= state_next;
            entry_wfe_reg <= entry_wfe_next;
            cnt_reg       <= cnt_next;
            lat_reg       <= lat_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            regulator_on     <= 1'b1;
            core_pwr_on      <= 1'b1;
            sram_pwr_on      <= 1'b1;
            periph_pwr_on    <= 1'b0;
            cpu_clk_on       <= 1'b1;
            mem_clk_on       <= 1'b1;
            periph_clk_on    <= 1'b0;
            cpu_reset        <= 1'b0;
            io_hold          <= 1'b0;
            io_default_cfg   <= 1'b0;
            fast_rc_restart  <= 1'b0;
            master_clk_on_rc <= 1'b1;
            fast_startup_req <= 1'b0;
            low_power_active <= 1'b0;
        end else begin
            regulator_on     <= regulator_next;
            core_pwr_on      <= core_pwr_next;
            sram_pwr_on      <= sram_pwr_next;
            periph_pwr_on    <= periph_pwr_next;
            cpu_clk_on       <= cpu_clk_next;
            mem_clk_on       <= mem_clk_next;
            periph_clk_on    <= periph_clk_next;
            cpu_reset        <= cpu_reset_next;
            io_hold          <= io_hold_next;
            io_default_cfg   <= io_default_next;
            fast_rc_restart  <= rc_restart_next;
            master_clk_on_rc <= mclk_rc_next;
            fast_startup_req <= fs_req_next;
            low_power_active <= ~n_active;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_backup_entry;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPWK_ACTIVE) && wfe_exec && deep_sleep_bit
        |=> (state_reg == LPWK_BACKUP) && !regulator_on && !core_pwr_on;
    endproperty
    a_backup_entry: assert property (p_backup_entry) else $error("backup not entered");

    property p_wait_entry;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPWK_ACTIVE) && wfe_exec && !deep_sleep_bit && low_power_select
        |=> (state_reg == LPWK_WAIT) && regulator_on && core_pwr_on && !cpu_clk_on;
    endproperty
    a_wait_entry: assert property (p_wait_entry) else $error("wait not entered");

    property p_sleep_entry;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPWK_ACTIVE) && (wfe_exec || wfi_exec)
        && !deep_sleep_bit && !low_power_select
        |=> (state_reg == LPWK_SLEEP) && core_pwr_on && !mem_clk_on;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

    property p_backup_stays;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPWK_BACKUP) && !backup_evt |=> (state_reg == LPWK_BACKUP);
    endproperty
    a_backup_stays: assert property (p_backup_stays) else $error("backup left without source");

    property p_hold_io;
        @(posedge core_clk) disable iff (rst)
        (state_reg != LPWK_ACTIVE) |-> io_hold;
    endproperty
    a_hold_io: assert property (p_hold_io) else $error("io hold wrong");

    property p_backup_budget;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPWK_BK_REG) || (state_reg == LPWK_BK_PWR) |-> lat_reg < BACKUP_BUDGET;
    endproperty
    a_backup_budget: assert property (p_backup_budget) else $error("backup wake too slow");

    property p_wait_budget;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPWK_FS_RC) |-> lat_reg < WAIT_BUDGET;
    endproperty
    a_wait_budget: assert property (p_wait_budget) else $error("wait wake too slow");

    property p_wfi_sleep;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPWK_SLEEP) && !entry_wfe_reg && !irq_pending
        |=> (state_reg == LPWK_SLEEP);
    endproperty
    a_wfi_sleep: assert property (p_wfi_sleep) else $error("sleep left without interrupt");

    property p_fast_req;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPWK_WAIT) && fast_evt |=> fast_startup_req ##0 (state_reg == LPWK_FS_RC);
    endproperty
    a_fast_req: assert property (p_fast_req) else $error("no fast startup request");

    property p_supply_restore;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPWK_BK_REG) && reg_done |=> core_pwr_on && sram_pwr_on && cpu_reset;
    endproperty
    a_supply_restore: assert property (p_supply_restore) else $error("supplies not restored");

    property p_rc_after_wake;
        @(posedge core_clk) disable iff (rst)
        (state_reg == LPWK_FS_RC) && rc_done |=> cpu_clk_on && master_clk_on_rc;
    endproperty
    a_rc_after_wake: assert property (p_rc_after_wake) else $error("not on RC after wake");

endmodule

// ===== sim/lpwk_cpu_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// Processor core: wait instructions, interrupts
// ----------------------------------------
module lpwk_cpu_model (
    input  wire logic core_clk,
    input  wire logic cpu_clk_on,
    output logic      wfe_exec,
    output logic      wfi_exec,
    output logic      deep_sleep_bit,
    output logic      low_power_select,
    output logic      irq_pending,
    output logic      master_clk_release
);
    initial begin
        wfe_exec           = 1'b0;
        wfi_exec           = 1'b0;
        deep_sleep_bit     = 1'b0;
        low_power_select   = 1'b0;
        irq_pending        = 1'b0;
        master_clk_release = 1'b0;
    end

    // A stopped core executes nothing, so wait for its clock first
    task automatic issue(input bit wait_for_interrupt_instruction, input bit ds, input bit lps);
        int n;
        n = 0;
        while (cpu_clk_on !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        deep_sleep_bit   <= ds;
        low_power_select <= lps;
        @(posedge core_clk);
        wfe_exec <= !wait_for_interrupt_instruction;
        wfi_exec <= wait_for_interrupt_instruction;
        @(posedge core_clk);
        wfe_exec <= 1'b0;
        wfi_exec <= 1'b0;
    endtask

    task automatic irq(input bit v);
        @(posedge core_clk);
        irq_pending <= v;
    endtask

    task automatic rel_clk;
        @(posedge core_clk);
        master_clk_release <= 1'b1;
        @(posedge core_clk);
        master_clk_release <= 1'b0;
    endtask
endmodule

// ===== sim/low_power_mode_wakeup_control_tb.sv
`timescale 1ns/10ps
`include "lpwk_defines.svh"

module low_power_mode_wakeup_control_tb;
    logic                     core_clk;
    logic                     rst;
    logic [`LPWK_NUM_SRC-1:0] src_n;
    logic [`LPWK_NUM_SRC-1:0] src_en;
    logic                     periph_domain_en;
    logic                     sleep_periph_clk_keep;
    logic wfe_exec, wfi_exec, deep_sleep_bit, low_power_select, irq_pending;
    logic master_clk_release, regulator_on, core_pwr_on, sram_pwr_on, periph_pwr_on;
    logic cpu_clk_on, mem_clk_on, periph_clk_on, cpu_reset, io_hold, io_default_cfg;
    logic fast_rc_restart, master_clk_on_rc, fast_startup_req, low_power_active;
    int   err_count, n_checks, mode, s, k;

    lpwk_cpu_model lpwk_cpu_model_inst (
        .core_clk, .cpu_clk_on, .wfe_exec, .wfi_exec, .deep_sleep_bit,
        .low_power_select, .irq_pending, .master_clk_release
    );

    // Short settling counts keep the backup sequence brief
    lpwk_ctrl #(
        .REG_SETTLE_CYC (16'h0014),
        .RC_SETTLE_CYC  (16'h0004)
    ) lpwk_ctrl_inst (
        .core_clk, .rst, .wfe_exec, .wfi_exec, .deep_sleep_bit, .low_power_select,
        .irq_pending, .wake_pins_n(src_n[15:0]), .wake_pins_en(src_en[15:0]),
        .supply_monitor_alarm_n(src_n[`LPWK_SRC_SM]), .supply_monitor_en(src_en[`LPWK_SRC_SM]),
        .calendar_alarm_n(src_n[`LPWK_SRC_CAL]), .calendar_en(src_en[`LPWK_SRC_CAL]),
        .real_time_timer_alarm_n(src_n[`LPWK_SRC_RTT]),
        .real_time_timer_en(src_en[`LPWK_SRC_RTT]),
        .usb_wakeup_n(src_n[`LPWK_SRC_USB]), .usb_wakeup_en(src_en[`LPWK_SRC_USB]),
        .periph_domain_en, .sleep_periph_clk_keep, .master_clk_release,
        .regulator_on, .core_pwr_on, .sram_pwr_on, .periph_pwr_on, .cpu_clk_on,
        .mem_clk_on, .periph_clk_on, .cpu_reset, .io_hold, .io_default_cfg,
        .fast_rc_restart, .master_clk_on_rc, .fast_startup_req, .low_power_active
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // ----------------------------------------
    // Checking and stimulus tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask

    function automatic int exp_mode(input bit wait_for_interrupt_instruction, input bit ds, input bit lps);
        if (wait_for_interrupt_instruction) return (ds || lps) ? 0 : 1;
        return ds ? 3 : (lps ? 2 : 1);
    endfunction

    task automatic rnd;
        @(posedge core_clk);
        periph_domain_en      <= 1'($urandom);
        sleep_periph_clk_keep <= 1'($urandom);
    endtask

    task automatic enter(input bit wait_for_interrupt_instruction, input bit ds, input bit lps);
        lpwk_cpu_model_inst.issue(wait_for_interrupt_instruction, ds, lps);
        mode = exp_mode(wait_for_interrupt_instruction, ds, lps);
        tick(1);
        chk("low_power_active", low_power_active, mode != 0);
        if (mode != 0) begin
            chk("core_clocks", {cpu_clk_on, mem_clk_on}, 2'b00);
            chk("io_hold", io_hold, 1'b1);
            chk("pwr", {regulator_on, core_pwr_on, sram_pwr_on}, {3{mode != 3}});
            chk("periph_pwr_on", periph_pwr_on, mode != 3 && periph_domain_en);
            chk("periph_clk_on", periph_clk_on,
                mode == 1 && periph_domain_en && sleep_periph_clk_keep);
        end
    endtask

    // Held long enough to pass the synchronisers several times over
    task automatic no_wake(input int src);
        logic fsr;
        fsr = 1'b0;
        @(posedge core_clk);
        src_n[src] <= 1'b0;
        repeat (12) begin
            tick(1);
            fsr = fsr | fast_startup_req;
        end
        chk("fast_startup_req", fsr, 1'b0);
        chk("low_power_active", low_power_active, 1'b1);
        @(posedge core_clk);
        src_n[src] <= 1'b1;
        tick(4);
    endtask

    // Index 20 stands for an interrupt instead of a wake line
    task automatic wake(input int src);
        int   n;
        logic fsr, rc, rs, cfg;
        n   = 0;
        fsr = 1'b0;
        rc  = 1'b0;
        rs  = 1'b0;
        cfg = 1'b0;
        if (src < `LPWK_NUM_SRC) begin
            @(posedge core_clk);
            src_n[src] <= 1'b0;
        end else begin
            lpwk_cpu_model_inst.irq(1'b1);
        end
        do begin
            tick(1);
            n++;
            fsr = fsr | fast_startup_req;
            rc  = rc | fast_rc_restart;
            rs  = rs | cpu_reset;
            cfg = cfg | io_default_cfg;
        end while (!(cpu_clk_on === 1'b1 && low_power_active === 1'b0) && n < 30000);
        if (n >= 30000) begin
            chk("wake_timeout", 1, 0);
            complete_run;
        end
        chk("woken_state", {cpu_reset, io_default_cfg, io_hold}, 3'b000);
        if (mode == 3) begin
            chk("bk_reset_seq", {rs, cfg}, 2'b11);
            chk("bk_supplies", {regulator_on, core_pwr_on, sram_pwr_on}, 3'b111);
            chk("bk_wake_time", n < `LPWK_BACKUP_WAKE_CYC, 1'b1);
        end
        if (mode == 2) begin
            if (src < `LPWK_SRC_USB) chk("wt_fast", {fsr, rc}, 2'b11);
            else chk("wt_usb_fast", fsr, 1'b0);
            chk("wt_no_reset", {rs, cfg}, 2'b00);
            chk("wt_wake_time", n < `LPWK_WAIT_WAKE_CYC, 1'b1);
        end
        if (mode >= 2) chk("master_clk_on_rc", master_clk_on_rc, 1'b1);
        if (src < `LPWK_NUM_SRC) begin
            @(posedge core_clk);
            src_n[src] <= 1'b1;
        end else begin
            lpwk_cpu_model_inst.irq(1'b0);
        end
        tick(4);
        mode = 0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(7682));
        err_count             = 0;
        n_checks              = 0;
        mode                  = 0;
        rst                   = 1'b1;
        src_n                 = '1;
        src_en                = '1;
        periph_domain_en      = 1'b1;
        sleep_periph_clk_keep = 1'b0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        tick(3);
        chk("reset_outputs", {regulator_on, core_pwr_on, sram_pwr_on, cpu_clk_on,
            master_clk_on_rc, cpu_reset, io_hold, low_power_active}, 8'hF8);
        enter(1'b1, 1'b1, 1'b0);
        enter(1'b1, 1'b0, 1'b1);
        for (s = 0; s < `LPWK_NUM_SRC; s++) begin
            rnd();
            enter(1'b0, 1'b0, 1'b1);
            wake(s);
        end
        repeat (3) begin
            s = $urandom_range(18, 0);
            @(posedge core_clk);
            src_en[s] <= 1'b0;
            enter(1'b0, 1'b0, 1'b1);
            no_wake(s);
            wake((s + 1) % 19);
            @(posedge core_clk);
            src_en <= '1;
        end
        for (k = 0; k < 3; k++) begin
            rnd();
            enter(k == 2, 1'b0, 1'b0);
            if (k == 2) no_wake(0);
            wake(k == 0 ? $urandom_range(19, 0) : 20);
        end
        lpwk_cpu_model_inst.rel_clk();
        tick(1);
        chk("master_clk_on_rc", master_clk_on_rc, 1'b0);
        for (k = 0; k < 5; k++) begin
            s = (k < 4) ? 15 + k : $urandom_range(14, 0);
            rnd();
            enter(1'b0, 1'b1, 1'($urandom));
            no_wake(`LPWK_SRC_USB);
            wake(s);
        end
        complete_run();
    end
endmodule
